//--- tlbinv_pkg.sv
// Package of constants and types for the TLB invalidation engine.
package tlbinv_pkg;
    localparam int NENT = 8;
    localparam int IW = 3;
    localparam int VPNW = 52;
    localparam int ABASE = 12;
    localparam int TBI_BIT = 56;
    // Command opcodes.
    localparam logic [7:0] OP_G_ALL = 8'h10;
    localparam logic [7:0] OP_G_SPACE = 8'h11;
    localparam logic [7:0] OP_G_ADDR = 8'h12;
    localparam logic [7:0] OP_G_AALL = 8'h13;
    localparam logic [7:0] OP_M_ALL = 8'h18;
    localparam logic [7:0] OP_M_ADDR = 8'h1A;
    localparam logic [7:0] OP_H_ALL = 8'h20;
    localparam logic [7:0] OP_H_ADDR = 8'h22;
    localparam logic [7:0] OP_H_AALL = 8'h23;
    localparam logic [7:0] OP_H_SPACE = 8'h24;
    localparam logic [7:0] OP_SYNC = 8'h46;
    localparam logic [7:0] ERR_ILLEGAL = 8'h01;
    // Translation worlds recorded with each entry.
    localparam logic [2:0] W_NS = 3'h0;
    localparam logic [2:0] W_SEC = 3'h1;
    localparam logic [2:0] W_MON = 3'h2;
    localparam logic [2:0] W_HYP = 3'h3;
    localparam logic [2:0] W_HOST = 3'h4;
    // Register byte addresses.
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_ID = 4'h4;
    localparam logic [3:0] A_STAT = 4'h8;
    // Control register fields.
    localparam int C_VMW = 0;
    localparam int C_VMWW = 1;
    localparam int C_HOST = 3;
    localparam int C_TBI = 4;
    localparam int C_VAS = 5;
    localparam logic [31:0] CTRL_RST = 32'h0000_0600;
    // Feature register fields.
    localparam int F_S1 = 0;
    localparam int F_S2 = 1;
    localparam int F_HYP = 2;
    localparam int F_WAS = 3;
    localparam int F_WVM = 4;
    localparam logic [31:0] ID_RST = 32'h0000_001F;
    // Status register fields.
    localparam int S_BUSY = 0;
    localparam int S_SYNC = 1;
    localparam int S_ERRC = 8;
    localparam int S_KILL = 16;
    localparam logic [7:0] ERRC_MAX = 8'hFF;

    typedef struct packed {
        logic [7:0] opcode;
        logic secure_q;
        logic [15:0] vmid;
        logic [15:0] asid;
        logic [VPNW-1:0] addr;
        logic leaf;
    } tlbinv_cmd_t;

    typedef struct packed {
        logic [2:0] world;
        logic global_e;
        logic broadcast_exempt_flag;
        logic last_level;
        logic [15:0] vmid;
        logic [15:0] asid;
        logic [VPNW-1:0] vpn;
    } tlbinv_entry_t;

    typedef struct packed {
        logic [2:0] world;
        logic [15:0] vmid;
        logic [15:0] asid;
        logic [VPNW-1:0] vpn;
    } tlbinv_look_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WALK = 2'b01,
        ST_SYNC = 2'b10
    } tlbinv_state_t;
endpackage

//--- tlbinv_engine.sv
// TLB with command-driven and broadcast invalidation, sync barrier.
//
// Contract
// - Invalidation never touches stalled transactions.
// - In-flight lookups unaffected; entries change atomically.
// - Sync waits until hit in-flight transactions finish; only the first to finish per entry is tracked.
// - Sync consumed only after earlier invalidations finish.
// - Commands act locally; no broadcast is emitted.
// - Wildcard applies to broadcasts and commands alike.
// - Narrow ids: non-zero upper byte invalidates nothing.
// - Space matching ignores the broadcast exempt flag.
// - Minimum scope met; no extra invalidation done.
// - Stage 2 only: stage 1 commands illegal.
// - Guest vm id matched only stage2 Non-secure.
// - Out-of-range addresses skipped; optional top byte ignore.
// - Guest flush-all scope depends on queue.
// - Guest flush-by-space: non-global, queue-dependent match.
// - Guest address all-spaces flush, includes global.
// - Guest address flush matches space or global.
// - Last-level-only flag restricts to leaf entries.
// - Monitor commands legal only on Secure queue.
// - No hypervisor support: hypervisor commands illegal.
// - Hypervisor flush-all hits tagged and untagged.
// - Hypervisor address commands follow host mode bit.
// - Hypervisor space flush hits non-global host entries.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
module tlbinv_engine (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command queue side
    input wire logic cmd_valid,
    input wire tlbinv_pkg::tlbinv_cmd_t cmd,
    output logic cmd_ready,
    output logic sync_done,
    output logic err_valid,
    output logic [7:0] err_code,
    // Received broadcast invalidations
    input wire logic bc_valid,
    input wire tlbinv_pkg::tlbinv_cmd_t bc_cmd,
    output logic bc_ready,
    // Entry fill
    input wire logic fill_valid,
    input wire logic [tlbinv_pkg::IW-1:0] fill_index,
    input wire tlbinv_pkg::tlbinv_entry_t fill_entry,
    // Translation lookup and completion
    input wire logic lk_valid,
    input wire tlbinv_pkg::tlbinv_look_t lk_req,
    output logic lk_hit,
    output logic [tlbinv_pkg::IW-1:0] lk_index,
    input wire logic txn_done,
    input wire logic [tlbinv_pkg::IW-1:0] txn_index,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata
);
    localparam int N = tlbinv_pkg::NENT;
    localparam int W = tlbinv_pkg::VPNW;
    tlbinv_pkg::tlbinv_state_t state_r;
    tlbinv_pkg::tlbinv_cmd_t hold_r;
    tlbinv_pkg::tlbinv_entry_t ent_r [N];
    logic [N-1:0] valid_r, inflight_r, killed_r;
    logic [tlbinv_pkg::IW-1:0] idx_r, lk_index_r;
    logic [31:0] ctrl_r, id_r, rdata_r;
    logic [7:0] errc_r, err_code_r;
    logic cmd_ready_r, bc_ready_r, sync_done_r, err_valid_r, lk_hit_r;
    logic take_cmd, take_bc, illegal, is_guest, is_mon, is_hyp;
    logic walk_hit, last_idx, lk_any;
    logic [tlbinv_pkg::IW-1:0] lk_first;
    logic [15:0] vm_wild, as_mask, vm_mask;
    logic [W-1:0] va_mask;
    assign take_cmd = cmd_valid && cmd_ready_r;
    assign take_bc = bc_valid && bc_ready_r && !take_cmd;
    assign last_idx = idx_r == tlbinv_pkg::IW'(N - 1);

    // Identifier and address compare masks from the configuration.
    always_comb begin
        as_mask = id_r[tlbinv_pkg::F_WAS] ? 16'hFFFF : 16'h00FF;
        vm_mask = id_r[tlbinv_pkg::F_WVM] ? 16'hFFFF : 16'h00FF;
        vm_wild = 16'h0000;
        if (ctrl_r[tlbinv_pkg::C_VMW]) begin
            vm_wild = 16'((17'h1 << ctrl_r[tlbinv_pkg::C_VMWW +: 2])
                - 17'h1);
        end
        va_mask = {W{1'b1}};
        if (ctrl_r[tlbinv_pkg::C_TBI]) begin
            va_mask[W-1 -: 8] = 8'h00;
        end
    end

    // Address is in range when all bits from the top VA bit agree.
    function automatic logic va_ok(input logic [W-1:0] a);
        logic ones, zeros, top;
        int va_size;
        ones = 1'b1;
        zeros = 1'b1;
        va_size = int'(ctrl_r[tlbinv_pkg::C_VAS +: 6]);
        for (int i = 0; i < W; i++) begin
            top = (i + tlbinv_pkg::ABASE >= va_size - 1) &&
                !(ctrl_r[tlbinv_pkg::C_TBI] &&
                i + tlbinv_pkg::ABASE >= tlbinv_pkg::TBI_BIT);
            ones = ones && (a[i] || !top);
            zeros = zeros && (!a[i] || !top);
        end
        return ones || zeros;
    endfunction

    // Minimum-scope match of one entry against one command.
    function automatic logic hit_f(
        input tlbinv_pkg::tlbinv_entry_t e,
        input tlbinv_pkg::tlbinv_cmd_t c
    );
        logic ns, vm_on, vmm, asm, vam;
        logic gw, host, use_as, addr_op, h;
        ns = !c.secure_q;
        host = ctrl_r[tlbinv_pkg::C_HOST];
        vm_on = ns && id_r[tlbinv_pkg::F_S2];
        vmm = ((e.vmid ^ c.vmid) & vm_mask & ~vm_wild) == 16'h0000;
        // Exempt flag deliberately left out of the compare.
        asm = ((e.asid ^ c.asid) & as_mask) == 16'h0000;
        vam = ((e.vpn ^ c.addr) & va_mask) == '0;
        gw = ns ? (e.world == tlbinv_pkg::W_NS && (!vm_on || vmm))
            : (e.world == tlbinv_pkg::W_SEC);
        use_as = 1'b0;
        addr_op = 1'b0;
        case (c.opcode)
            tlbinv_pkg::OP_G_ALL: h = gw;
            tlbinv_pkg::OP_G_SPACE: begin
                h = gw && !e.global_e && asm;
                use_as = 1'b1;
            end
            tlbinv_pkg::OP_G_AALL: begin
                h = gw && vam;
                addr_op = 1'b1;
            end
            tlbinv_pkg::OP_G_ADDR: begin
                h = gw && vam && (asm || e.global_e);
                use_as = 1'b1;
                addr_op = 1'b1;
            end
            tlbinv_pkg::OP_M_ALL: h = e.world == tlbinv_pkg::W_MON;
            tlbinv_pkg::OP_M_ADDR: begin
                h = e.world == tlbinv_pkg::W_MON && vam;
                addr_op = 1'b1;
            end
            tlbinv_pkg::OP_H_ALL: h = e.world == tlbinv_pkg::W_HYP ||
                e.world == tlbinv_pkg::W_HOST;
            tlbinv_pkg::OP_H_ADDR: begin
                h = host ? (e.world == tlbinv_pkg::W_HOST && vam &&
                    (asm || e.global_e))
                    : (e.world == tlbinv_pkg::W_HYP && vam);
                use_as = host;
                addr_op = 1'b1;
            end
            tlbinv_pkg::OP_H_AALL: begin
                h = vam && (host ? e.world == tlbinv_pkg::W_HOST
                    : e.world == tlbinv_pkg::W_HYP);
                addr_op = 1'b1;
            end
            tlbinv_pkg::OP_H_SPACE: begin
                h = e.world == tlbinv_pkg::W_HOST && !e.global_e &&
                    asm;
                use_as = 1'b1;
            end
            default: h = 1'b0;
        endcase
        if (use_as && (c.asid & ~as_mask) != 16'h0000) begin
            h = 1'b0;
        end
        if (vm_on && (c.vmid & ~vm_mask) != 16'h0000 &&
            c.opcode inside {tlbinv_pkg::OP_G_ALL, tlbinv_pkg::OP_G_SPACE,
            tlbinv_pkg::OP_G_AALL, tlbinv_pkg::OP_G_ADDR}) begin
            h = 1'b0;
        end
        if (addr_op) begin
            h = h && va_ok(c.addr);
            h = h && (!c.leaf || e.last_level);
        end
        return h;
    endfunction

    // Legality of a command taken from a queue.
    always_comb begin
        is_guest = cmd.opcode inside {tlbinv_pkg::OP_G_ALL,
            tlbinv_pkg::OP_G_SPACE, tlbinv_pkg::OP_G_AALL,
            tlbinv_pkg::OP_G_ADDR};
        is_mon = cmd.opcode inside {tlbinv_pkg::OP_M_ALL,
            tlbinv_pkg::OP_M_ADDR};
        is_hyp = cmd.opcode inside {tlbinv_pkg::OP_H_ALL,
            tlbinv_pkg::OP_H_ADDR, tlbinv_pkg::OP_H_AALL,
            tlbinv_pkg::OP_H_SPACE};
        illegal = !(is_guest || is_mon || is_hyp ||
            cmd.opcode == tlbinv_pkg::OP_SYNC);
        illegal = illegal || ((is_guest || is_mon || is_hyp) &&
            !id_r[tlbinv_pkg::F_S1]);
        illegal = illegal || (is_mon && !cmd.secure_q);
        illegal = illegal || (is_hyp && !id_r[tlbinv_pkg::F_HYP]);
    end

    assign walk_hit = state_r == tlbinv_pkg::ST_WALK &&
        valid_r[idx_r] && hit_f(ent_r[idx_r], hold_r);

    // Sequencer: accept, walk one entry a cycle, hold a sync.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= tlbinv_pkg::ST_IDLE;
            hold_r <= '0;
            idx_r <= '0;
            cmd_ready_r <= 1'b0;
            bc_ready_r <= 1'b0;
            sync_done_r <= 1'b0;
        end else begin
            sync_done_r <= 1'b0;
            case (state_r)
                tlbinv_pkg::ST_IDLE: begin
                    // An illegal command leaves both ports ready.
                    cmd_ready_r <= !(take_cmd && !illegal) && !take_bc;
                    bc_ready_r <= !(take_cmd && !illegal) && !take_bc;
                    if (take_cmd && !illegal &&
                        cmd.opcode == tlbinv_pkg::OP_SYNC) begin
                        state_r <= tlbinv_pkg::ST_SYNC;
                    end else if (take_cmd && !illegal) begin
                        hold_r <= cmd;
                        idx_r <= '0;
                        state_r <= tlbinv_pkg::ST_WALK;
                    end else if (take_bc) begin
                        hold_r <= bc_cmd;
                        hold_r.secure_q <= 1'b0;
                        idx_r <= '0;
                        state_r <= tlbinv_pkg::ST_WALK;
                    end
                end
                tlbinv_pkg::ST_WALK: begin
                    idx_r <= idx_r + 1'b1;
                    if (last_idx) begin
                        cmd_ready_r <= 1'b1;
                        bc_ready_r <= 1'b1;
                        state_r <= tlbinv_pkg::ST_IDLE;
                    end
                end
                tlbinv_pkg::ST_SYNC: begin
                    // Hit transactions must have left before release.
                    if (killed_r == '0) begin
                        sync_done_r <= 1'b1;
                        cmd_ready_r <= 1'b1;
                        bc_ready_r <= 1'b1;
                        state_r <= tlbinv_pkg::ST_IDLE;
                    end
                end
                default: state_r <= tlbinv_pkg::ST_IDLE;
            endcase
        end
    end

    // Error report for illegal commands.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_valid_r <= 1'b0;
            err_code_r <= 8'h00;
            errc_r <= 8'h00;
        end else begin
            err_valid_r <= take_cmd && illegal;
            if (take_cmd && illegal) begin
                err_code_r <= tlbinv_pkg::ERR_ILLEGAL;
                if (errc_r != tlbinv_pkg::ERRC_MAX) begin
                    errc_r <= errc_r + 8'h01;
                end
            end
        end
    end

    // Entry contents; valid and fields change in the same edge.
    always_ff @(posedge clk) begin
        if (fill_valid) begin
            ent_r[fill_index] <= fill_entry;
        end
    end

    // An invalidated slot clears even if a fill hits it that edge,
    // so a walk can never be undone by a racing refill.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid_r <= '0;
        end else begin
            if (fill_valid) begin
                valid_r[fill_index] <= 1'b1;
            end
            if (walk_hit) begin
                valid_r[idx_r] <= 1'b0;
            end
        end
    end

    // Lookup: first valid matching entry, answered next cycle.
    always_comb begin
        lk_any = 1'b0;
        lk_first = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (valid_r[i] && ent_r[i].world == lk_req.world &&
                ent_r[i].vmid == lk_req.vmid &&
                (ent_r[i].global_e || ent_r[i].asid == lk_req.asid) &&
                ent_r[i].vpn == lk_req.vpn) begin
                lk_any = 1'b1;
                lk_first = tlbinv_pkg::IW'(i);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lk_hit_r <= 1'b0;
            lk_index_r <= '0;
        end else begin
            lk_hit_r <= lk_valid && lk_any;
            lk_index_r <= lk_first;
        end
    end

    // One in-flight bit per entry: several transactions on one
    // entry are tracked by the first to finish only. Invalidation
    // never aborts them; stalled ones stay in flight untouched.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inflight_r <= '0;
            killed_r <= '0;
        end else begin
            if (txn_done) begin
                inflight_r[txn_index] <= 1'b0;
                killed_r[txn_index] <= 1'b0;
            end
            if (lk_valid && lk_any) begin
                inflight_r[lk_first] <= 1'b1;
            end
            if (walk_hit && inflight_r[idx_r]) begin
                killed_r[idx_r] <= 1'b1;
            end
        end
    end

    // Register file.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= tlbinv_pkg::CTRL_RST;
            id_r <= tlbinv_pkg::ID_RST;
        end else if (reg_we) begin
            if (reg_addr == tlbinv_pkg::A_CTRL) begin
                ctrl_r <= reg_wdata;
            end
            if (reg_addr == tlbinv_pkg::A_ID) begin
                id_r <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= 32'h0000_0000;
            if (reg_re) begin
                case (reg_addr)
                    tlbinv_pkg::A_CTRL: rdata_r <= ctrl_r;
                    tlbinv_pkg::A_ID: rdata_r <= id_r;
                    tlbinv_pkg::A_STAT: begin
                        rdata_r[tlbinv_pkg::S_BUSY] <=
                            state_r != tlbinv_pkg::ST_IDLE;
                        rdata_r[tlbinv_pkg::S_SYNC] <=
                            state_r == tlbinv_pkg::ST_SYNC;
                        rdata_r[tlbinv_pkg::S_ERRC +: 8] <= errc_r;
                        rdata_r[tlbinv_pkg::S_KILL +: N] <= killed_r;
                    end
                    default: rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // No broadcast output exists: invalidation stays in this TLB.
    assign cmd_ready = cmd_ready_r;
    assign bc_ready = bc_ready_r;
    assign sync_done = sync_done_r;
    assign err_valid = err_valid_r;
    assign err_code = err_code_r;
    assign lk_hit = lk_hit_r;
    assign lk_index = lk_index_r;
    assign reg_rdata = rdata_r;
endmodule

//--- tlbinv_engine_sva.sv
// Port assertions for the TLB invalidation engine.
`timescale 1ns/1ps
module tlbinv_engine_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command queue side
    input wire logic cmd_valid,
    input wire tlbinv_pkg::tlbinv_cmd_t cmd,
    input wire logic cmd_ready,
    input wire logic sync_done,
    input wire logic err_valid,
    input wire logic [7:0] err_code,
    // Lookup side
    input wire logic lk_valid,
    input wire logic lk_hit
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic take;
    assign take = cmd_valid && cmd_ready;
    property p_mon_ns;
        take && cmd.opcode == tlbinv_pkg::OP_M_ALL && !cmd.secure_q
            |=> err_valid && cmd_ready;
    endproperty
    a_mon_ns: assert property (p_mon_ns)
        else $error("monitor flush taken from non-secure queue");
    property p_err_code;
        err_valid |-> err_code == tlbinv_pkg::ERR_ILLEGAL;
    endproperty
    a_err_code: assert property (p_err_code)
        else $error("wrong error code");
    property p_err_cause;
        err_valid |-> $past(take);
    endproperty
    a_err_cause: assert property (p_err_cause)
        else $error("error pulse without a command");
    // The walk length pins the atomic eight-entry sweep.
    property p_walk;
        take && cmd.opcode == tlbinv_pkg::OP_G_ADDR ##1 !err_valid
            |-> !cmd_ready [*8] ##1 cmd_ready;
    endproperty
    a_walk: assert property (p_walk)
        else $error("guest address walk has wrong length");
    property p_hyp_walk;
        take && cmd.opcode == tlbinv_pkg::OP_H_ADDR ##1 !err_valid
            |-> !cmd_ready [*8] ##1 cmd_ready;
    endproperty
    a_hyp_walk: assert property (p_hyp_walk)
        else $error("hypervisor address walk has wrong length");
    property p_sync_hold;
        take && cmd.opcode == tlbinv_pkg::OP_SYNC |=> !cmd_ready;
    endproperty
    a_sync_hold: assert property (p_sync_hold)
        else $error("sync did not hold the queue");
    property p_sync_pulse;
        sync_done |=> !sync_done && cmd_ready;
    endproperty
    a_sync_pulse: assert property (p_sync_pulse)
        else $error("sync completion not a single pulse");
    property p_lk_cause;
        lk_hit |-> $past(lk_valid);
    endproperty
    a_lk_cause: assert property (p_lk_cause)
        else $error("hit without a lookup");
endmodule
bind tlbinv_engine tlbinv_engine_sva tlbinv_engine_sva_inst (.clk, .rst,
    .cmd_valid, .cmd, .cmd_ready, .sync_done, .err_valid, .err_code,
    .lk_valid, .lk_hit);

//--- tlbinv_sw_model.sv
// Software command queue model offering one command at a time.
`timescale 1ns/1ps
module tlbinv_sw_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Test control
    input wire logic go,
    input wire tlbinv_pkg::tlbinv_cmd_t next_cmd,
    // Command port
    output logic cmd_valid,
    output tlbinv_pkg::tlbinv_cmd_t cmd,
    input wire logic cmd_ready
);
    // A released command word turns to its inverse, so the engine
    // cannot lean on stale fields after the take.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_valid <= 1'b0;
            cmd <= '0;
        end else if (go) begin
            cmd_valid <= 1'b1;
            cmd <= next_cmd;
        end else if (cmd_valid && cmd_ready) begin
            cmd_valid <= 1'b0;
            cmd <= ~cmd;
        end
    end
endmodule

//--- tlbinv_engine_tb.sv
// Command-level testbench for the TLB invalidation engine.
`timescale 1ns/1ps
module tlbinv_engine_tb;
    logic clk, cmd_valid, cmd_ready, sync_done, err_valid, bc_ready, lk_hit;
    logic rst = 1'b1, go = 1'b0, bc_valid = 1'b0, fill_valid = 1'b0;
    logic lk_valid = 1'b0, txn_done = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
    logic [2:0] fill_index = 3'h0, txn_index = 3'h0, lk_index;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] err_code;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    tlbinv_pkg::tlbinv_cmd_t cmd, next_cmd = '0, bc_cmd = '0;
    tlbinv_pkg::tlbinv_entry_t fill_entry = '0;
    tlbinv_pkg::tlbinv_look_t lk_req = '0;
    int n_errors = 0, compares = 0, err_seen = 0, sync_seen = 0;
    tlbinv_engine tlbinv_engine_inst (.clk, .rst, .cmd_valid, .cmd,
        .cmd_ready, .sync_done, .err_valid, .err_code, .bc_valid, .bc_cmd,
        .bc_ready, .fill_valid, .fill_index, .fill_entry, .lk_valid, .lk_req,
        .lk_hit, .lk_index, .txn_done, .txn_index, .reg_addr, .reg_wdata,
        .reg_we, .reg_re, .reg_rdata);
    tlbinv_sw_model tlbinv_sw_model_inst (.clk, .rst, .go, .next_cmd,
        .cmd_valid, .cmd, .cmd_ready);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (err_valid === 1'b1) err_seen++;
        if (sync_done === 1'b1) sync_seen++;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 chk(reg_rdata, exp);
        @(posedge clk);
    endtask
    task automatic fill(input logic [2:0] i,
            input tlbinv_pkg::tlbinv_entry_t e);
        fill_valid <= 1'b1;
        fill_index <= i;
        fill_entry <= e;
        @(posedge clk);
        fill_valid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic look(input tlbinv_pkg::tlbinv_look_t l, input logic exp,
            input logic done);
        logic [2:0] ix;
        lk_valid <= 1'b1;
        lk_req <= l;
        @(posedge clk);
        lk_valid <= 1'b0;
        #1 chk(32'(lk_hit), 32'(exp));
        ix = lk_index;
        @(posedge clk);
        txn_done <= done & exp;
        txn_index <= ix;
        @(posedge clk);
        txn_done <= 1'b0;
    endtask
    task automatic issue(input tlbinv_pkg::tlbinv_cmd_t c);
        go <= 1'b1;
        next_cmd <= c;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic idle();
        for (int k = 0; k < 60; k++) begin
            @(posedge clk);
            if (!cmd_valid && cmd_ready === 1'b1) return;
        end
        n_errors++;
        $display("[FAIL] %0t command never completed", $time);
        tally_and_finish();
    endtask
    task automatic send(input tlbinv_pkg::tlbinv_cmd_t c);
        issue(c);
        idle();
    endtask
    // Every entry carries the exempt flag, which space matching must skip.
    function automatic tlbinv_pkg::tlbinv_entry_t ent(logic [2:0] w,
            logic g, logic ll, logic [15:0] vm, logic [15:0] a,
            logic [51:0] v);
        return '{w, g, 1'b1, ll, vm, a, v};
    endfunction
    function automatic tlbinv_pkg::tlbinv_cmd_t cm(logic [7:0] op, logic s,
            logic [15:0] vm, logic [15:0] a, logic [51:0] v, logic lf);
        return '{op, s, vm, a, v, lf};
    endfunction
    function automatic tlbinv_pkg::tlbinv_look_t lk(logic [2:0] w,
            logic [15:0] vm, logic [15:0] a, logic [51:0] v);
        return '{w, vm, a, v};
    endfunction
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(tlbinv_pkg::A_ID, tlbinv_pkg::ID_RST);
        rd(tlbinv_pkg::A_CTRL, tlbinv_pkg::CTRL_RST);
        rd(4'hC, 32'h0);
        fill(3'h0, ent(tlbinv_pkg::W_NS, 0, 1, 16'h1, 16'h5, 52'h1));
        fill(3'h1, ent(tlbinv_pkg::W_NS, 1, 1, 16'h1, 16'h5, 52'h2));
        fill(3'h2, ent(tlbinv_pkg::W_NS, 0, 1, 16'h1, 16'h6, 52'h3));
        send(cm(tlbinv_pkg::OP_G_SPACE, 0, 16'h1, 16'h5, 52'h0, 0));
        look(lk(tlbinv_pkg::W_NS, 16'h1, 16'h5, 52'h1), 0, 1);
        look(lk(tlbinv_pkg::W_NS, 16'h1, 16'h7, 52'h2), 1, 1);
        look(lk(tlbinv_pkg::W_NS, 16'h1, 16'h6, 52'h3), 1, 1);
        wr(tlbinv_pkg::A_ID, 32'h0000_0007);
        send(cm(tlbinv_pkg::OP_G_SPACE, 0, 16'h1, 16'h0106, 52'h0, 0));
        look(lk(tlbinv_pkg::W_NS, 16'h1, 16'h6, 52'h3), 1, 1);
        wr(tlbinv_pkg::A_ID, tlbinv_pkg::ID_RST);
        send(cm(tlbinv_pkg::OP_M_ALL, 0, 16'h0, 16'h0, 52'h0, 0));
        send(cm(tlbinv_pkg::OP_M_ADDR, 0, 16'h0, 16'h0, 52'h2, 0));
        look(lk(tlbinv_pkg::W_NS, 16'h1, 16'h5, 52'h2), 1, 1);
        chk(err_seen, 2);
        rd(tlbinv_pkg::A_STAT, 32'h0000_0200);
        fill(3'h3, ent(tlbinv_pkg::W_HYP, 0, 1, 16'h0, 16'h3, 52'h7));
        fill(3'h4, ent(tlbinv_pkg::W_HOST, 0, 1, 16'h0, 16'h3, 52'h7));
        send(cm(tlbinv_pkg::OP_H_ADDR, 0, 16'h0, 16'h3, 52'h7, 0));
        look(lk(tlbinv_pkg::W_HYP, 16'h0, 16'h3, 52'h7), 0, 1);
        look(lk(tlbinv_pkg::W_HOST, 16'h0, 16'h3, 52'h7), 1, 1);
        wr(tlbinv_pkg::A_CTRL, 32'h0000_0608);
        send(cm(tlbinv_pkg::OP_H_ADDR, 0, 16'h0, 16'h3, 52'h7, 0));
        look(lk(tlbinv_pkg::W_HOST, 16'h0, 16'h3, 52'h7), 0, 1);
        wr(tlbinv_pkg::A_CTRL, tlbinv_pkg::CTRL_RST);
        wr(tlbinv_pkg::A_ID, 32'h0000_001B);
        send(cm(tlbinv_pkg::OP_H_ALL, 0, 16'h0, 16'h0, 52'h0, 0));
        wr(tlbinv_pkg::A_ID, 32'h0000_001E);
        send(cm(tlbinv_pkg::OP_G_ALL, 0, 16'h1, 16'h0, 52'h0, 0));
        look(lk(tlbinv_pkg::W_NS, 16'h1, 16'h5, 52'h2), 1, 1);
        chk(err_seen, 4);
        wr(tlbinv_pkg::A_ID, tlbinv_pkg::ID_RST);
        fill(3'h6, ent(tlbinv_pkg::W_NS, 0, 0, 16'h1, 16'h2, 52'h4));
        send(cm(tlbinv_pkg::OP_G_AALL, 0, 16'h1, 16'h0, 52'h4, 1));
        look(lk(tlbinv_pkg::W_NS, 16'h1, 16'h2, 52'h4), 1, 1);
        send(cm(tlbinv_pkg::OP_G_AALL, 0, 16'h1, 16'h0, 52'h4, 0));
        look(lk(tlbinv_pkg::W_NS, 16'h1, 16'h2, 52'h4), 0, 1);
        fill(3'h5, ent(tlbinv_pkg::W_NS, 0, 1, 16'h0, 16'h1, 52'h9));
        look(lk(tlbinv_pkg::W_NS, 16'h0, 16'h1, 52'h9), 1, 0);
        send(cm(tlbinv_pkg::OP_G_ADDR, 0, 16'h0, 16'h1, 52'h9, 0));
        issue(cm(tlbinv_pkg::OP_SYNC, 0, 16'h0, 16'h0, 52'h0, 0));
        repeat (6) @(posedge clk);
        chk(sync_seen, 0);
        txn_done <= 1'b1;
        txn_index <= 3'h5;
        @(posedge clk);
        txn_done <= 1'b0;
        idle();
        #1 chk(sync_seen, 1);
        look(lk(tlbinv_pkg::W_NS, 16'h0, 16'h1, 52'h9), 0, 1);
        tally_and_finish();
    end
endmodule
